// [rtl/itc_defines.svh]
`ifndef ITC_DEFINES_SVH
`define ITC_DEFINES_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define ITC_OFS_TMR_MODE 8'hf1
`define ITC_OFS_RELOAD 8'hf4
`define ITC_OFS_PRESCALE 8'hf5
`define ITC_OFS_PRIORITY 8'hf9
`define ITC_OFS_PENDING 8'hfa
`define ITC_OFS_MASK 8'hfb
`define ITC_OFS_STATUS 8'hfc
`define ITC_OFS_IRQ_MASK 8'hfd
// ****************************************************************
// Field positions
// ****************************************************************
`define ITC_TM_LOAD 0
`define ITC_TM_RUN 1
`define ITC_TM_CONT 2
`define ITC_MASK_GLOBAL 7
`define ITC_PEND_STOP 6
`define ITC_PEND_HOT 7
`define ITC_ST_GRANT 0
`define ITC_ST_TIMER 1
// ****************************************************************
// Reset values and counts
// ****************************************************************
`define ITC_RST_BYTE 8'h00
`define ITC_RST_PRIO 3'h0
`define ITC_RST_PINS 4'hf
`define ITC_NUM_SRC 5
`define ITC_VEC_BYTES 12
`endif

// [rtl/itc_pkg.sv]
package itc_pkg;
    typedef logic [7:0] itc_byte_t;
    typedef logic [15:0] itc_addr_t;
    typedef logic [4:0] itc_src_t;
    typedef logic [2:0] itc_idx_t;
    typedef enum logic [1:0] {
        ITC_IDLE,
        ITC_VEC_LO,
        ITC_VEC_HI,
        ITC_WAIT_ACK
    } itc_state_t;
endpackage : itc_pkg

// [rtl/itc_ctrl.sv]
`timescale 1ns/1ps
`include "itc_defines.svh"

// Overview of operation
// - Five sources: four low port 3 input lines and the down-counter timer.
// - Mask register has a global enable bit and one enable bit per source.
// - Priority register selects ordering among simultaneously pending requests.
// - Grant disables interrupts, saves PC and flags, jumps via source vector.
// - Vectors fill the lowest 10 program bytes, 16-bit, byte pair per source.
// - Requests latch into the pending register even while masked, for polling.
// - 6-bit prescaler divides by 1 to 64; each overflow steps the counter.
// - Counter loads 1 to 256, decrements on overflow, end of count raises request.
// - Single-pass mode halts at zero; continuous mode reloads and keeps going.
// - Software can start, stop, resume from present count, restart from load.
// - Counter is readable without disturbing it; prescaler is not readable.
// - Hot bit reads 0 after power-up, set when watchdog time-out caused reset.
// - Hot bit is read-only and clears on any read of it.
// - Stop bit set on stop entry; 1 means warm recovery, 0 cold.
// - During halt timer and pin requests stay active; any interrupt ends halt.
module itc_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output itc_pkg::itc_byte_t reg_rdata,
    // Pin requests and core status
    input wire logic [3:0] port3_low_inputs,
    input wire logic watchdog_reset_cause,
    input wire logic stop_entry,
    input wire logic halt_active,
    output logic halt_wake,
    // Grant path to the core and vector memory
    output logic grant_req,
    output itc_pkg::itc_idx_t grant_source,
    output itc_pkg::itc_byte_t vec_mem_addr,
    input wire logic [7:0] vec_mem_data,
    output itc_pkg::itc_addr_t grant_vector,
    output logic grant_save_ctx,
    output logic global_irq_off,
    input wire logic core_ack,
    // Timer pulse and event interrupt
    output logic timer_request_line,
    output logic irq
);
    import itc_pkg::*;

    // ****************************************************************
    // Register storage
    // ****************************************************************
    // Register map seen by software:
    //   0xf1 write: timer mode bits; read: present counter value
    //   0xf4 counter load value, 0 counts 256 steps
    //   0xf5 prescaler load, write only, 0 divides by 64
    //   0xf9 rotating start source of the priority search
    //   0xfa pending flags: sources 4:0, stop flag 6, hot flag 7
    //   0xfb enable mask: sources 4:0, global enable 7
    //   0xfc event status, write one to clear
    //   0xfd event mask for the level interrupt output
    // Software-visible state
    itc_byte_t timer_mode_control;
    itc_byte_t reload_value;
    logic [5:0] prescale_load;
    logic [2:0] priority_sel;
    itc_byte_t request_pending_flags;
    itc_byte_t request_enable_mask;
    logic [1:0] event_status;
    logic [1:0] event_mask;
    // Internal counting and tracking state
    itc_byte_t main_downcounter;
    logic [5:0] prescale_count;
    logic [3:0] pins_prev;
    logic hot_seen;
    itc_state_t state;
    itc_idx_t cur_src;

    // Decoded strobes and combinational request paths
    logic wr_tm;
    logic rd_pend;
    logic wr_pend;
    logic wr_status;
    logic tick_pre;
    logic end_of_count;
    logic grant_fire;
    itc_src_t pin_edges;
    itc_src_t raw_req;
    itc_src_t eligible;
    itc_idx_t next_src;
    logic next_any;

    assign wr_tm = reg_wr && (reg_addr == `ITC_OFS_TMR_MODE);
    assign rd_pend = reg_rd && (reg_addr == `ITC_OFS_PENDING);
    assign wr_pend = reg_wr && (reg_addr == `ITC_OFS_PENDING);
    assign wr_status = reg_wr && (reg_addr == `ITC_OFS_STATUS);

    // Falling edge on a pin is a request; pins held low do not retrigger
    // A line must return high before it can request again
    assign pin_edges = {1'b0, pins_prev & ~port3_low_inputs};
    assign raw_req = {end_of_count, pin_edges[3:0]};

    // ****************************************************************
    // Timer: prescaler and down-counter
    // ****************************************************************
    // Mode bits: load reloads both stages, run lets them count,
    // continuous reloads the counter at end of count
    // End of count is the prescaler tick that finds the counter at one,
    // so a load of n gives exactly n prescaler periods per request
    // Prescaler load of 0 means divide by 64, so 1..64 all reachable
    assign tick_pre = timer_mode_control[`ITC_TM_RUN] && (prescale_count == 6'd1);
    assign end_of_count = tick_pre && (main_downcounter == 8'd1);

    // Prescaler runs freely in halt since nothing here gates it
    // A load write wins over a tick in the same cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prescale_count <= 6'd0;
        end else if (wr_tm && reg_wdata[`ITC_TM_LOAD]) begin
            prescale_count <= prescale_load;
        end else if (tick_pre) begin
            prescale_count <= prescale_load;
        end else if (timer_mode_control[`ITC_TM_RUN]) begin
            prescale_count <= prescale_count - 6'd1;
        end
    end

    // Load value 0 counts 256 steps
    // Stopping only freezes it, so a later run resumes from here
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            main_downcounter <= `ITC_RST_BYTE;
        end else if (wr_tm && reg_wdata[`ITC_TM_LOAD]) begin
            main_downcounter <= reload_value;
        end else if (tick_pre) begin
            main_downcounter <= main_downcounter - 8'd1;
            if (end_of_count && timer_mode_control[`ITC_TM_CONT]) begin
                main_downcounter <= reload_value;
            end
        end
    end

    // Run bit drops at zero in single-pass mode; load bit is self-clearing
    // Unused upper bits are tied to zero
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            timer_mode_control <= `ITC_RST_BYTE;
        end else if (wr_tm) begin
            timer_mode_control <= {5'd0, reg_wdata[`ITC_TM_CONT], reg_wdata[`ITC_TM_RUN], 1'b0};
        end else if (end_of_count && !timer_mode_control[`ITC_TM_CONT]) begin
            timer_mode_control[`ITC_TM_RUN] <= 1'b0;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // Plain settings, read-write except the write-only prescaler load; pending and status have their own
    // processes because hardware events also write them
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reload_value <= `ITC_RST_BYTE;
            prescale_load <= 6'd0;
            priority_sel <= `ITC_RST_PRIO;
            request_enable_mask <= `ITC_RST_BYTE;
            event_mask <= 2'b00;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `ITC_OFS_RELOAD: reload_value <= reg_wdata;
                `ITC_OFS_PRESCALE: prescale_load <= reg_wdata[5:0];
                `ITC_OFS_PRIORITY: priority_sel <= reg_wdata[2:0];
                `ITC_OFS_MASK: request_enable_mask <= {reg_wdata[7], 2'b00, reg_wdata[4:0]};
                `ITC_OFS_IRQ_MASK: event_mask <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // Last pin levels; reset to the pulled-up idle level, so no false
    // edge appears when reset ends while the lines rest high
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pins_prev <= `ITC_RST_PINS;
        end else begin
            pins_prev <= port3_low_inputs;
        end
    end

    // Watchdog cause caught after release, never loaded by the async reset
    // Only the first cycle after release may set the hot flag
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hot_seen <= 1'b0;
        end else begin
            hot_seen <= 1'b1;
        end
    end

    // ****************************************************************
    // Pending register
    // ****************************************************************
    // Latching ignores the mask so polling software sees everything
    // Per source a new event beats a software write, which beats the
    // acknowledge clear, so no event is lost to a race with software
    // Hot flag is set only in the first cycle after reset, cleared by a read
    // Stop flag is set on stop entry and otherwise writable
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            request_pending_flags <= `ITC_RST_BYTE;
        end else begin
            for (int i = 0; i < `ITC_NUM_SRC; i++) begin
                if (raw_req[i]) begin
                    request_pending_flags[i] <= 1'b1;
                end else if (wr_pend) begin
                    request_pending_flags[i] <= reg_wdata[i];
                end else if (core_ack && state == ITC_WAIT_ACK && cur_src == i[2:0]) begin
                    request_pending_flags[i] <= 1'b0;
                end
            end
            if (!hot_seen && watchdog_reset_cause) begin
                request_pending_flags[`ITC_PEND_HOT] <= 1'b1;
            end else if (rd_pend) begin
                request_pending_flags[`ITC_PEND_HOT] <= 1'b0;
            end
            if (stop_entry) begin
                request_pending_flags[`ITC_PEND_STOP] <= 1'b1;
            end else if (wr_pend) begin
                request_pending_flags[`ITC_PEND_STOP] <= reg_wdata[`ITC_PEND_STOP];
            end
        end
    end

    // ****************************************************************
    // Priority encoder
    // ****************************************************************
    // Rotating start point: search begins at the source the register names
    // The loop walks from the far end back to the start source, so the
    // last hit, nearest the start, is the one kept
    // Start values above four simply wrap modulo the source count
    assign eligible = request_pending_flags[4:0] & request_enable_mask[4:0]
        & {5{request_enable_mask[`ITC_MASK_GLOBAL]}};
    always_comb begin
        itc_idx_t idx;
        idx = 3'd0;
        next_src = 3'd0;
        next_any = 1'b0;
        for (int k = `ITC_NUM_SRC - 1; k >= 0; k--) begin
            idx = 3'((int'(priority_sel) + k) % `ITC_NUM_SRC);
            if (eligible[idx]) begin
                next_src = idx;
                next_any = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Grant sequencer
    // ****************************************************************
    assign grant_fire = (state == ITC_IDLE) && next_any;

    // Vector bytes fetched high then low; core saves context on grant
    // Cycle after fire: context save pulse, interrupts off, first address
    // Next cycle: high byte taken, address steps to the low byte
    // Next cycle: low byte taken, grant raised to the core
    // Grant and interrupts off stay until the core acknowledges
    // Vector memory must answer in the same cycle, one byte per cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= ITC_IDLE;
            cur_src <= 3'd0;
            vec_mem_addr <= `ITC_RST_BYTE;
            grant_vector <= 16'h0000;
            grant_req <= 1'b0;
            grant_save_ctx <= 1'b0;
            grant_source <= 3'd0;
            global_irq_off <= 1'b0;
        end else begin
            grant_save_ctx <= 1'b0;
            unique case (state)
                ITC_IDLE: begin
                    if (grant_fire) begin
                        cur_src <= next_src;
                        grant_source <= next_src;
                        vec_mem_addr <= {4'h0, next_src, 1'b0};
                        global_irq_off <= 1'b1;
                        grant_save_ctx <= 1'b1;
                        state <= ITC_VEC_LO;
                    end
                end
                ITC_VEC_LO: begin
                    grant_vector[15:8] <= vec_mem_data;
                    vec_mem_addr <= vec_mem_addr + 8'd1;
                    state <= ITC_VEC_HI;
                end
                ITC_VEC_HI: begin
                    grant_vector[7:0] <= vec_mem_data;
                    grant_req <= 1'b1;
                    state <= ITC_WAIT_ACK;
                end
                ITC_WAIT_ACK: begin
                    if (core_ack) begin
                        grant_req <= 1'b0;
                        global_irq_off <= 1'b0;
                        state <= ITC_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Outputs, wake and event interrupt
    // ****************************************************************
    // Timer pulse mirrors end of count one cycle late
    // Wake needs an enabled pending source or any raw event, masked or not
    // Event status bits: set wins over a clear written in the same cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            timer_request_line <= 1'b0;
            halt_wake <= 1'b0;
            event_status <= 2'b00;
            irq <= 1'b0;
        end else begin
            timer_request_line <= end_of_count;
            halt_wake <= halt_active && (eligible != 5'd0 || raw_req != 5'd0);
            for (int j = 0; j < 2; j++) begin
                if ((j == `ITC_ST_GRANT && grant_fire) || (j == `ITC_ST_TIMER && end_of_count)) begin
                    event_status[j] <= 1'b1;
                end else if (wr_status && reg_wdata[j]) begin
                    event_status[j] <= 1'b0;
                end
            end
            irq <= |(event_status & event_mask);
        end
    end

    // Read mux; prescaler deliberately absent, unmapped reads zero
    // Read data stands one cycle only, so a late sampler sees zero
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= `ITC_RST_BYTE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `ITC_OFS_TMR_MODE: begin
                    reg_rdata <= main_downcounter;
                end
                `ITC_OFS_RELOAD: begin
                    reg_rdata <= reload_value;
                end
                `ITC_OFS_PRIORITY: begin
                    reg_rdata <= {5'd0, priority_sel};
                end
                `ITC_OFS_PENDING: begin
                    reg_rdata <= request_pending_flags;
                end
                `ITC_OFS_MASK: begin
                    reg_rdata <= request_enable_mask;
                end
                `ITC_OFS_STATUS: begin
                    reg_rdata <= {6'd0, event_status};
                end
                `ITC_OFS_IRQ_MASK: begin
                    reg_rdata <= {6'd0, event_mask};
                end
                default: begin
                    reg_rdata <= `ITC_RST_BYTE;
                end
            endcase
        end else begin
            reg_rdata <= `ITC_RST_BYTE;
        end
    end
endmodule : itc_ctrl

// [tb/itc_ctrl_sva.sv]
`timescale 1ns/1ps
// ********
// Grant path and register port checks
// ********
module itc_ctrl_sva (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_rd,
    input itc_pkg::itc_byte_t reg_rdata,
    input wire logic grant_req,
    input itc_pkg::itc_idx_t grant_source,
    input itc_pkg::itc_byte_t vec_mem_addr,
    input wire logic [7:0] vec_mem_data,
    input itc_pkg::itc_addr_t grant_vector,
    input wire logic grant_save_ctx,
    input wire logic global_irq_off,
    input wire logic core_ack,
    input wire logic timer_request_line
);
    import itc_pkg::*;
    // Single domain, so clock and reset are given once
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    AST_RD_SLOT: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the answer slot");
    AST_SAVE_GRANT: assert property (grant_save_ctx |-> ##2 grant_req)
        else $error("vector not ready two cycles after save");
    AST_SAVE_OFF: assert property (grant_save_ctx |-> global_irq_off ##1 !grant_save_ctx)
        else $error("save pulse without interrupts off");
    AST_SRC: assert property (grant_save_ctx |-> grant_source < 3'd5)
        else $error("granted source out of range");
    AST_VADDR: assert property (grant_save_ctx |-> vec_mem_addr == {4'h0, grant_source, 1'b0}
        ##1 vec_mem_addr == $past(vec_mem_addr) + 8'h01) else $error("vector fetch address");
    AST_VEC: assert property ($rose(grant_req) |->
        grant_vector == {$past(vec_mem_data, 2), $past(vec_mem_data)}) else $error("vector bytes");
    AST_HOLD: assert property (grant_req && !core_ack |=> grant_req && global_irq_off)
        else $error("grant dropped before acknowledge");
    AST_ACK: assert property (grant_req && core_ack |=> !grant_req && !global_irq_off)
        else $error("grant kept after acknowledge");
    // Main scenarios reached
    COV_ACK: cover property (grant_req && core_ack);
    COV_TIMER: cover property (timer_request_line);
    COV_PIN_D: cover property (grant_save_ctx && grant_source == 3'd3);
endmodule : itc_ctrl_sva

// [tb/itc_core_model.sv]
`timescale 1ns/1ps
// ********
// Core and vector memory stand-in
// ********
module itc_core_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic grant_req,
    input itc_pkg::itc_byte_t vec_mem_addr,
    input wire logic [1:0] dly,
    output logic core_ack,
    output itc_pkg::itc_byte_t vec_mem_data
);
    import itc_pkg::*;
    logic [1:0] wait_cnt;
    // Bytes differ from their address, so a swapped or shifted fetch shows
    assign vec_mem_data = vec_mem_addr ^ 8'ha5;
    // Acknowledge after a chosen stall; a pulse, never held, to avoid a double ack
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            core_ack <= 1'b0;
            wait_cnt <= 2'd0;
        end else begin
            core_ack <= 1'b0;
            if (grant_req && !core_ack) begin
                core_ack <= (wait_cnt == dly);
                wait_cnt <= (wait_cnt == dly) ? 2'd0 : wait_cnt + 2'd1;
            end
        end
    end
endmodule : itc_core_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "itc_defines.svh"
bind itc_ctrl itc_ctrl_sva u_sva (.core_clk, .reset, .reg_rd, .reg_rdata, .grant_req,
    .grant_source, .vec_mem_addr, .vec_mem_data, .grant_vector, .grant_save_ctx,
    .global_irq_off, .core_ack, .timer_request_line);
module tb_top;
    import itc_pkg::*;
    logic core_clk, reset, reg_wr, reg_rd, watchdog_reset_cause, stop_entry, halt_active;
    logic halt_wake, grant_req, grant_save_ctx, global_irq_off, core_ack;
    logic timer_request_line, irq, rd_d = 1'b0, gr_d = 1'b0, woke;
    logic [7:0] reg_addr, reg_wdata, p, n, m;
    logic [3:0] port3_low_inputs;
    logic [1:0] dly;
    itc_byte_t reg_rdata, vec_mem_addr, vec_mem_data;
    itc_idx_t grant_source;
    itc_addr_t grant_vector;
    logic [18:0] rq[$], gq[$];
    int fails = 0, n_tests = 0, tcnt = 0, src;
    itc_ctrl dut (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .port3_low_inputs, .watchdog_reset_cause, .stop_entry, .halt_active, .halt_wake,
        .grant_req, .grant_source, .vec_mem_addr, .vec_mem_data, .grant_vector,
        .grant_save_ctx, .global_irq_off, .core_ack, .timer_request_line, .irq);
    itc_core_model u_core (.core_clk, .reset, .grant_req, .vec_mem_addr, .dly, .core_ack,
        .vec_mem_data);
    // ********
    // Clock, shared tasks and result watcher
    // ********
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(string nm, logic [18:0] e, logic [18:0] s);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic cyc(int k);
        repeat (k) @(posedge core_clk);
    endtask : cyc
    // An idle edge follows each strobe, so no strobe is set twice in one step
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(1);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        rq.push_back({11'h0, e});
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        cyc(1);
    endtask : rd
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    // Read data is only valid the cycle after the strobe; grants on rising request
    always @(posedge core_clk) begin
        if (rd_d) chk("reg_rdata", rq.pop_front(), {11'h0, reg_rdata});
        if (grant_req && !gr_d) chk("grant", gq.pop_front(), {grant_source, grant_vector});
        if (timer_request_line) tcnt++;
        if (halt_wake) woke = 1'b1;
        rd_d <= reg_rd;
        gr_d <= grant_req;
    end
    initial begin
        cyc(20000);
        fails++;
        complete_run();
    end
    // ********
    // Scenarios
    // ********
    initial begin
        void'($urandom(32'h1d72ea69));
        {reset, reg_wr, reg_rd, watchdog_reset_cause, stop_entry, halt_active} = 6'b100000;
        {reg_addr, reg_wdata, port3_low_inputs, dly} = {8'h00, 8'h00, 4'hf, 2'd0};
        cyc(6);
        reset <= 1'b0;
        cyc(2);
        p = 8'd2 + 8'($urandom % 6);
        n = 8'd2 + 8'($urandom % 5);
        wr(`ITC_OFS_RELOAD, n);
        wr(`ITC_OFS_TMR_MODE, 8'h01);
        rd(`ITC_OFS_TMR_MODE, n);
        wr(`ITC_OFS_PRESCALE, p);
        rd(`ITC_OFS_PRESCALE, 8'h00);
        rd(8'h10, 8'h00);
        rd(`ITC_OFS_PENDING, 8'h00);
        $display("test registers done");
        woke = 1'b0;
        tcnt = 0;
        halt_active <= 1'b1;
        wr(`ITC_OFS_TMR_MODE, 8'h07);
        cyc(32'(p) * n * 3 + 32'(p) * n / 2);
        chk("timer pulses", 19'd3, 19'(tcnt));
        chk("halt wake", 19'd1, {18'h0, woke});
        halt_active <= 1'b0;
        wr(`ITC_OFS_TMR_MODE, 8'h00);
        rd(`ITC_OFS_PENDING, 8'h10);
        rd(`ITC_OFS_STATUS, 8'h02);
        wr(`ITC_OFS_IRQ_MASK, 8'h02);
        cyc(1);
        chk("irq", 19'd1, {18'h0, irq});
        wr(`ITC_OFS_STATUS, 8'h02);
        cyc(1);
        chk("irq", 19'd0, {18'h0, irq});
        tcnt = 0;
        wr(`ITC_OFS_TMR_MODE, 8'h03);
        cyc(32'(p) * n * 3);
        chk("single pass pulses", 19'd1, 19'(tcnt));
        // Stop keeps the count; run again resumes from it, not from the load
        wr(`ITC_OFS_TMR_MODE, 8'h01);
        rd(`ITC_OFS_TMR_MODE, n);
        wr(`ITC_OFS_TMR_MODE, 8'h02);
        cyc(32'(p) - 1);
        wr(`ITC_OFS_TMR_MODE, 8'h00);
        rd(`ITC_OFS_TMR_MODE, n - 8'd1);
        wr(`ITC_OFS_TMR_MODE, 8'h02);
        cyc(32'(p) - 2);
        wr(`ITC_OFS_TMR_MODE, 8'h00);
        rd(`ITC_OFS_TMR_MODE, n - 8'd2);
        wr(`ITC_OFS_PENDING, 8'h00);
        $display("test timer done");
        for (int s = 0; s < 5; s++) begin
            m = 8'($urandom % 32);
            dly <= 2'($urandom);
            wr(`ITC_OFS_MASK, m);
            wr(`ITC_OFS_PRIORITY, 8'(s));
            port3_low_inputs <= 4'h0;
            cyc(2);
            rd(`ITC_OFS_PENDING, 8'h0f);
            for (int k = 0; k < 5; k++) begin
                src = (s + k) % 5;
                if (src < 4 && m[src])
                    gq.push_back({3'(src), 8'(2 * src) ^ 8'ha5, 8'(2 * src + 1) ^ 8'ha5});
            end
            wr(`ITC_OFS_MASK, 8'h80 | m);
            for (int t = 0; t < 200 && gq.size() > 0; t++) cyc(1);
            cyc(6);
            rd(`ITC_OFS_PENDING, 8'h0f & ~m);
            port3_low_inputs <= 4'hf;
            wr(`ITC_OFS_PENDING, 8'h00);
        end
        $display("test priority done");
        stop_entry <= 1'b1;
        cyc(1);
        stop_entry <= 1'b0;
        rd(`ITC_OFS_PENDING, 8'h40);
        reset <= 1'b1;
        cyc(2);
        {reset, watchdog_reset_cause} <= 2'b01;
        cyc(1);
        watchdog_reset_cause <= 1'b0;
        rd(`ITC_OFS_PENDING, 8'h80);
        rd(`ITC_OFS_PENDING, 8'h00);
        wr(`ITC_OFS_PENDING, 8'h80);
        rd(`ITC_OFS_PENDING, 8'h00);
        $display("test restart flags done");
        cyc(2);
        complete_run();
    end
endmodule : tb_top
